// >>> rtl/pgm_err_cnt.sv
// Saturating idle error counter that clears on read.
// Assumes the reader passes back the value it reported, so that errors
// counted after the snapshot survive the clear.
`default_nettype none

module pgm_err_cnt (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic inc,
   input wire logic clr,
   input wire logic [pgm_pkg::ERR_CNT_W-1:0] seen,
   output logic [pgm_pkg::ERR_CNT_W-1:0] cnt_q
);

   logic [pgm_pkg::ERR_CNT_W-1:0] base; // Value left after the clear

   ////////////////////////////////////////////////////////////////////////
   // Subtract only what was reported, then count the new error
   always_comb
   begin
      base = clr ? (cnt_q - seen) : cnt_q;
   end

   // Saturate rather than wrap: a wrapped count would hide a bad link
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cnt_q <= '0;
      end
      else if (inc && base != pgm_pkg::ERR_CNT_MAX)
      begin
         cnt_q <= base + 8'h01;
      end
      else
      begin
         cnt_q <= base;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/pgm_mmd_ptr.sv
// Stored register address for indirect management data accesses.
// Assumes load and step never matter together; load has priority.
`default_nettype none

module pgm_mmd_ptr (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic step,
   output logic [15:0] addr_q
);

   ////////////////////////////////////////////////////////////////////////
   // Address register; wraps at the top of the 16-bit space
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         addr_q <= 16'h0000;
      end
      else if (load)
      begin
         addr_q <= load_val;
      end
      else if (step)
      begin
         addr_q <= addr_q + 16'h0001;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/pgm_pkg.sv
// Constants, field layouts and state types for the next-page, gigabit
// control/status and indirect management register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses; each 16-bit
// register takes one aligned word at four times its index.
`default_nettype none

package pgm_pkg;

   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_EXPANSION = 6'h06;
   localparam logic [5:0] IDX_NP_TX = 6'h07;
   localparam logic [5:0] IDX_NP_RX = 6'h08;
   localparam logic [5:0] IDX_GIG_CTRL = 6'h09;
   localparam logic [5:0] IDX_GIG_STAT = 6'h0a;
   localparam logic [5:0] IDX_MMD_CTRL = 6'h0d;
   localparam logic [5:0] IDX_MMD_DATA = 6'h0e;
   localparam logic [5:0] IDX_STAT_EXT1 = 6'h0f;

   // Next-page transmit fields
   localparam int NP_MORE_BIT = 15;
   localparam int NP_MSG_BIT = 13;
   localparam int NP_ACK2_BIT = 12;
   localparam int NP_TOGGLE_BIT = 11;
   localparam int NP_CODE_MSB = 10;
   localparam logic [15:0] NP_TX_RST = 16'h2001;
   localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;

   // Gigabit control fields
   localparam int GC_TEST_LSB = 13;
   localparam int GC_MANUAL_BIT = 12;
   localparam int GC_MS_VAL_BIT = 11;
   localparam int GC_PORT_BIT = 10;
   localparam int GC_ADV_FDX_BIT = 9;
   localparam int GC_ADV_HDX_BIT = 8;
   localparam logic [15:0] GIG_CTRL_RST = 16'h0700;

   // Gigabit status: idle counter width and fixed extension word
   localparam int ERR_CNT_W = 8;
   localparam logic [7:0] ERR_CNT_MAX = 8'hff;
   localparam logic [15:0] STAT_EXT1_VAL = 16'h3000;
   localparam int PAGE_RX_BIT = 1;

   // Indirect access control fields and function codes
   localparam int MC_FN_LSB = 14;
   localparam int MC_DEV_MSB = 4;
   localparam logic [1:0] FN_ADDRESS = 2'h0;
   localparam logic [1:0] FN_DATA = 2'h1;
   localparam logic [1:0] FN_DATA_INC_RW = 2'h2;
   localparam logic [1:0] FN_DATA_INC_W = 2'h3;
   localparam logic [15:0] MMD_CTRL_RST = 16'h0000;

   // Sticky flag slots
   localparam int FLAG_FAULT = 0;
   localparam int FLAG_PAGE = 1;
   localparam int NUM_FLAGS = 2;

   // Bus slave sequencing
   typedef enum logic [1:0] {
      PGM_IDLE,
      PGM_MMD,
      PGM_DONE
   } pgm_bus_e;

endpackage

`default_nettype wire

// >>> rtl/pgm_regs.sv
// Top of the register bank: Avalon-MM slave, next-page words, gigabit
// control and status, and the indirect management window.
// Assumes the negotiation engine and coding layer drive the status inputs
// synchronously to core_clk; indirect data lives outside and answers a
// request with a one-cycle acknowledge.
`default_nettype none

module pgm_regs (
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Negotiation engine side
   input wire logic lcw_sent,
   input wire logic lcw_sent_toggle,
   input wire logic page_rx,
   input wire logic [15:0] page_rx_word,
   input wire logic ms_fault,
   input wire logic ms_resolved_master,
   input wire logic local_rx_ok,
   input wire logic remote_rx_ok,
   input wire logic link_partner_full_duplex,
   input wire logic link_partner_half_duplex,
   input wire logic idle_error,
   output logic [15:0] np_tx_word,
   output logic np_tx_load,
   output logic [2:0] test_mode,
   output logic force_master,
   output logic force_slave,
   output logic multi_port,
   output logic adv_full_duplex,
   output logic adv_half_duplex,
   // Indirect management data port
   output logic mmd_req,
   output logic mmd_we,
   output logic [4:0] target_device_select,
   output logic [15:0] mmd_addr,
   output logic [15:0] mmd_wdata,
   input wire logic mmd_ack,
   input wire logic [15:0] mmd_rdata
);

   pgm_pkg::pgm_bus_e state_q; // Bus slave sequence
   logic [15:0] np_tx_q; // Writable next-page fields
   logic toggle_q; // Toggle for the next word
   logic [15:0] np_rx_q; // Last partner next page
   logic [15:0] gig_ctrl_q; // Gigabit control
   logic [15:0] mmd_ctrl_q; // Indirect access control
   logic resolved_q; // Resolution, master is one
   logic local_ok_q; // Local receiver good
   logic remote_ok_q; // Remote receiver good
   logic lp_fdx_q; // Partner gigabit full duplex
   logic lp_hdx_q; // Partner gigabit half duplex
   logic [pgm_pkg::NUM_FLAGS-1:0] flag_q; // Sticky event flags
   logic [pgm_pkg::NUM_FLAGS-1:0] flag_set; // Hardware events
   logic [pgm_pkg::NUM_FLAGS-1:0] flag_clr; // Read of the flag's register
   logic [pgm_pkg::NUM_FLAGS-1:0] flag_seen; // Values the read reported
   logic [15:0] rdata; // Read mux
   logic [15:0] rdata_q; // Word returned, kept for the clears
   logic [15:0] wmask; // Byte lanes of the write
   logic [5:0] idx; // Word index of the access
   logic [5:0] idx_q; // Index held for the completing edge
   logic [1:0] fn; // Current indirect function
   logic is_data; // Access goes through the indirect window
   logic done_rd; // Read completes this edge
   logic done_wr; // Write completes this edge
   logic ptr_load; // Write of the stored address
   logic ptr_step; // Advance after a data access
   logic [7:0] err_cnt; // Idle error count
   logic [15:0] ptr; // Stored indirect address
   logic [15:0] mmd_rd_q; // Data returned by the window

   ////////////////////////////////////////////////////////////////////////
   // Decode
   always_comb
   begin
      idx = avs_address[7:2];
      fn = mmd_ctrl_q[pgm_pkg::MC_FN_LSB +: 2];
      wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      // Data functions reach the outside only for a data register access
      is_data = (idx == pgm_pkg::IDX_MMD_DATA) &&
                (fn != pgm_pkg::FN_ADDRESS);
      done_rd = (state_q == pgm_pkg::PGM_DONE) && avs_read;
      done_wr = (state_q == pgm_pkg::PGM_DONE) && avs_write;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped words read as zero
   always_comb
   begin
      rdata = 16'h0000;
      unique case (idx)
         pgm_pkg::IDX_EXPANSION:
         begin
            rdata[pgm_pkg::PAGE_RX_BIT] = flag_q[pgm_pkg::FLAG_PAGE];
         end
         pgm_pkg::IDX_NP_TX:
         begin
            rdata = np_tx_q;
            rdata[pgm_pkg::NP_TOGGLE_BIT] = toggle_q;
         end
         pgm_pkg::IDX_NP_RX:
         begin
            rdata = np_rx_q;
         end
         pgm_pkg::IDX_GIG_CTRL:
         begin
            rdata = gig_ctrl_q;
         end
         pgm_pkg::IDX_GIG_STAT:
         begin
            rdata = {flag_q[pgm_pkg::FLAG_FAULT], resolved_q, local_ok_q,
                     remote_ok_q, lp_fdx_q, lp_hdx_q, 2'b00,
                     err_cnt};
         end
         pgm_pkg::IDX_MMD_CTRL:
         begin
            rdata = mmd_ctrl_q;
         end
         pgm_pkg::IDX_MMD_DATA:
         begin
            rdata = is_data ? mmd_rd_q : ptr;
         end
         pgm_pkg::IDX_STAT_EXT1:
         begin
            rdata = pgm_pkg::STAT_EXT1_VAL;
         end
         default:
         begin
            rdata = 16'h0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: answer one cycle after the request, or after the window
   // acknowledges. Writes and read side effects land on the edge where
   // the master sees waitrequest low.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= pgm_pkg::PGM_IDLE;
         avs_waitrequest <= 1'b1;
         rdata_q <= 16'h0000;
         idx_q <= 6'h00;
         mmd_req <= 1'b0;
         mmd_we <= 1'b0;
         mmd_wdata <= 16'h0000;
         mmd_rd_q <= 16'h0000;
      end
      else
      begin
         unique case (state_q)
            pgm_pkg::PGM_IDLE:
            begin
               if ((avs_read || avs_write) && is_data)
               begin
                  // Stall the bus until the indirect register answers
                  mmd_req <= 1'b1;
                  mmd_we <= avs_write;
                  mmd_wdata <= avs_writedata[15:0];
                  state_q <= pgm_pkg::PGM_MMD;
               end
               else if (avs_read || avs_write)
               begin
                  rdata_q <= rdata;
                  idx_q <= idx;
                  avs_waitrequest <= 1'b0;
                  state_q <= pgm_pkg::PGM_DONE;
               end
            end
            pgm_pkg::PGM_MMD:
            begin
               if (mmd_ack)
               begin
                  mmd_req <= 1'b0;
                  mmd_rd_q <= mmd_rdata;
                  rdata_q <= mmd_we ? 16'h0000 : mmd_rdata;
                  idx_q <= idx;
                  avs_waitrequest <= 1'b0;
                  state_q <= pgm_pkg::PGM_DONE;
               end
            end
            pgm_pkg::PGM_DONE:
            begin
               avs_waitrequest <= 1'b1;
               state_q <= pgm_pkg::PGM_IDLE;
            end
         endcase
      end
   end

   // Read data stays on the bus from the answer until the next one
   assign avs_readdata = {16'h0000, rdata_q};

   ////////////////////////////////////////////////////////////////////////
   // Next-page transmit word; toggle is owned by the engine
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         np_tx_q <= pgm_pkg::NP_TX_RST;
         np_tx_load <= 1'b0;
      end
      else
      begin
         np_tx_load <= done_wr && idx_q == pgm_pkg::IDX_NP_TX;
         if (done_wr && idx_q == pgm_pkg::IDX_NP_TX)
         begin
            np_tx_q <= (np_tx_q & ~(wmask & pgm_pkg::NP_TX_WMASK)) |
                       (avs_writedata[15:0] & wmask &
                        pgm_pkg::NP_TX_WMASK);
         end
      end
   end

   // Toggle follows the inverse of the word just sent
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         toggle_q <= 1'b0;
      end
      else if (lcw_sent)
      begin
         toggle_q <= ~lcw_sent_toggle;
      end
   end

   always_comb
   begin
      np_tx_word = np_tx_q;
      np_tx_word[pgm_pkg::NP_TOGGLE_BIT] = toggle_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Partner next page capture
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         np_rx_q <= 16'h0000;
      end
      else if (page_rx)
      begin
         np_rx_q <= page_rx_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gigabit control; test modes need media sense off first, which is
   // the manager's job and not checked here
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         gig_ctrl_q <= pgm_pkg::GIG_CTRL_RST;
      end
      else if (done_wr && idx_q == pgm_pkg::IDX_GIG_CTRL)
      begin
         gig_ctrl_q <= (gig_ctrl_q & ~wmask) |
                       (avs_writedata[15:0] & wmask);
      end
   end

   // Reserved test codes pass through; the transmitter treats them
   always_comb
   begin
      test_mode = gig_ctrl_q[pgm_pkg::GC_TEST_LSB +: 3];
      // Value bit has no effect unless manual configuration is on
      force_master = gig_ctrl_q[pgm_pkg::GC_MANUAL_BIT] &
                     gig_ctrl_q[pgm_pkg::GC_MS_VAL_BIT];
      force_slave = gig_ctrl_q[pgm_pkg::GC_MANUAL_BIT] &
                    ~gig_ctrl_q[pgm_pkg::GC_MS_VAL_BIT];
      multi_port = gig_ctrl_q[pgm_pkg::GC_PORT_BIT];
      adv_full_duplex = gig_ctrl_q[pgm_pkg::GC_ADV_FDX_BIT];
      adv_half_duplex = gig_ctrl_q[pgm_pkg::GC_ADV_HDX_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // Gigabit status levels, registered from the engine
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         resolved_q <= 1'b1;
         local_ok_q <= 1'b0;
         remote_ok_q <= 1'b0;
         lp_fdx_q <= 1'b0;
         lp_hdx_q <= 1'b0;
      end
      else
      begin
         resolved_q <= ms_resolved_master;
         local_ok_q <= local_rx_ok;
         remote_ok_q <= remote_rx_ok;
         lp_fdx_q <= link_partner_full_duplex;
         lp_hdx_q <= link_partner_half_duplex;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags: a set in the clearing cycle wins, and a clear only
   // drops what the read reported
   always_comb
   begin
      flag_set[pgm_pkg::FLAG_FAULT] = ms_fault;
      flag_set[pgm_pkg::FLAG_PAGE] = page_rx;
      flag_clr[pgm_pkg::FLAG_FAULT] = done_rd &&
                                      idx_q == pgm_pkg::IDX_GIG_STAT;
      flag_clr[pgm_pkg::FLAG_PAGE] = done_rd &&
                                     idx_q == pgm_pkg::IDX_EXPANSION;
      flag_seen[pgm_pkg::FLAG_FAULT] = rdata_q[15];
      flag_seen[pgm_pkg::FLAG_PAGE] = rdata_q[pgm_pkg::PAGE_RX_BIT];
   end

   for (genvar i = 0; i < pgm_pkg::NUM_FLAGS; i++)
   begin : g_flag
      always_ff @(posedge core_clk)
      begin
         if (rst)
         begin
            flag_q[i] <= 1'b0;
         end
         else
         begin
            flag_q[i] <= flag_set[i] |
                         (flag_q[i] & ~(flag_clr[i] & flag_seen[i]));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Idle error counter, cleared by reading the status word
   pgm_err_cnt u_err_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .inc(idle_error),
      .clr(done_rd && idx_q == pgm_pkg::IDX_GIG_STAT),
      .seen(rdata_q[7:0]),
      .cnt_q(err_cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   // Indirect access control; reserved bits are kept as written
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         mmd_ctrl_q <= pgm_pkg::MMD_CTRL_RST;
      end
      else if (done_wr && idx_q == pgm_pkg::IDX_MMD_CTRL)
      begin
         mmd_ctrl_q <= (mmd_ctrl_q & ~wmask) |
                       (avs_writedata[15:0] & wmask);
      end
   end

   assign target_device_select = mmd_ctrl_q[pgm_pkg::MC_DEV_MSB:0];

   // Address writes under function zero; step after qualifying data access
   always_comb
   begin
      ptr_load = done_wr && idx_q == pgm_pkg::IDX_MMD_DATA &&
                 fn == pgm_pkg::FN_ADDRESS;
      ptr_step = (done_rd || done_wr) && idx_q == pgm_pkg::IDX_MMD_DATA &&
                 (fn == pgm_pkg::FN_DATA_INC_RW ||
                  (fn == pgm_pkg::FN_DATA_INC_W && done_wr));
   end

   pgm_mmd_ptr u_mmd_ptr (
      .core_clk(core_clk),
      .rst(rst),
      .load(ptr_load),
      .load_val((ptr & ~wmask) | (avs_writedata[15:0] & wmask)),
      .step(ptr_step),
      .addr_q(ptr)
   );

   assign mmd_addr = ptr;

endmodule

`default_nettype wire

// >>> verif/pgm_regs_chk.sv
// Checker for the register bank: bus handshake, register effects, and
// the indirect data port. Bound to pgm_regs by port name.
`default_nettype none

module pgm_regs_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic lcw_sent,
   input wire logic lcw_sent_toggle,
   input wire logic ms_fault,
   input wire logic ms_resolved_master,
   input wire logic local_rx_ok,
   input wire logic remote_rx_ok,
   input wire logic link_partner_full_duplex,
   input wire logic link_partner_half_duplex,
   input wire logic [15:0] np_tx_word,
   input wire logic [2:0] test_mode,
   input wire logic force_master,
   input wire logic force_slave,
   input wire logic multi_port,
   input wire logic adv_full_duplex,
   input wire logic adv_half_duplex,
   input wire logic mmd_req,
   input wire logic mmd_we,
   input wire logic [15:0] mmd_addr,
   input wire logic mmd_ack,
   input wire logic [15:0] mmd_rdata
);
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Completing edges; partial-lane writes are left to the bench
   logic [5:0] idx;
   logic wr_done;
   logic rd_done;
   logic [15:0] wd_q; // Write data of the previous edge
   assign idx = avs_address[7:2];
   assign wr_done = !avs_waitrequest && avs_write &&
                    avs_byteenable[1:0] == 2'b11;
   assign rd_done = !avs_waitrequest && avs_read;
   always_ff @(posedge core_clk)
      wd_q <= avs_writedata[15:0];

   // Request taken for a register that answers without the far side
   sequence s_take;
      avs_waitrequest && (avs_read || avs_write) &&
      idx != pgm_pkg::IDX_MMD_DATA;
   endsequence
   // Far side answers a pending indirect access
   sequence s_ack;
      mmd_req && mmd_ack;
   endsequence
   ////////////////////////////////////////////////////////////
   wait_one_a:
   assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer stood longer than one cycle");
   plain_answer_a:
   assert property (s_take |=> !avs_waitrequest)
      else $error("plain register answer late");
   toggle_inv_a:
   assert property (lcw_sent |=> np_tx_word[11] == !$past(lcw_sent_toggle))
      else $error("toggle bit not inverted");
   np_write_a:
   assert property (wr_done && idx == pgm_pkg::IDX_NP_TX |=>
      (np_tx_word & 16'hb7ff) == (wd_q & 16'hb7ff))
      else $error("next page word not written");
   gig_ctrl_a:
   assert property (wr_done && idx == pgm_pkg::IDX_GIG_CTRL |=>
      test_mode == wd_q[15:13] && force_master == (wd_q[12] & wd_q[11]) &&
      force_slave == (wd_q[12] & !wd_q[11]) &&
      {multi_port, adv_full_duplex, adv_half_duplex} == wd_q[10:8])
      else $error("gigabit control outputs wrong");
   fault_read_a:
   assert property (rd_done && idx == pgm_pkg::IDX_GIG_STAT &&
      $past(ms_fault, 2) |-> avs_readdata[15])
      else $error("fault flag not latched");
   stat_read_a:
   assert property (rd_done && idx == pgm_pkg::IDX_GIG_STAT |->
      avs_readdata[14:10] == $past({ms_resolved_master, local_rx_ok,
      remote_rx_ok, link_partner_full_duplex, link_partner_half_duplex}, 2))
      else $error("status levels wrong");
   ext_read_a:
   assert property (rd_done && idx == pgm_pkg::IDX_STAT_EXT1 |->
      avs_readdata == 32'h0000_3000)
      else $error("extension word wrong");
   mmd_hold_a:
   assert property (mmd_req && !mmd_ack |=> mmd_req && $stable(mmd_addr))
      else $error("indirect request dropped early");
   mmd_done_a:
   assert property (s_ack |=> !mmd_req && !avs_waitrequest &&
      avs_readdata[15:0] == ($past(mmd_we) ? 16'h0000 : $past(mmd_rdata)))
      else $error("indirect answer wrong");
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the register bank, one task per scenario.
// Assumes pgm_pkg, pgm_regs and pgm_regs_chk are compiled before it.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %s", $time, m); end end
   ////////////////////////////////////////////////////////////
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h3;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic lcw_sent = 1'b0, lcw_sent_toggle = 1'b0, page_rx = 1'b0;
   logic [15:0] page_rx_word = 16'h0000;
   logic ms_fault = 1'b0, ms_resolved_master = 1'b1, local_rx_ok = 1'b0;
   logic remote_rx_ok = 1'b0, link_partner_full_duplex = 1'b0;
   logic link_partner_half_duplex = 1'b0, idle_error = 1'b0;
   logic [15:0] np_tx_word, mmd_addr, mmd_wdata;
   logic [2:0] test_mode;
   logic [4:0] target_device_select;
   logic np_tx_load, force_master, force_slave, multi_port;
   logic adv_full_duplex, adv_half_duplex, mmd_req, mmd_we;
   logic mmd_ack = 1'b0;
   logic [15:0] mmd_rdata = 16'h0000;
   logic [15:0] last_wa = 16'h0000, last_wd = 16'h0000; // Last far write
   int ack_wait = 0;
   int errors = 0;
   int compares = 0;

   always #5 core_clk = ~core_clk; // 100 MHz

   pgm_regs DUT (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .lcw_sent, .lcw_sent_toggle, .page_rx, .page_rx_word, .ms_fault,
      .ms_resolved_master, .local_rx_ok, .remote_rx_ok,
      .link_partner_full_duplex, .link_partner_half_duplex, .idle_error,
      .np_tx_word, .np_tx_load, .test_mode, .force_master, .force_slave,
      .multi_port, .adv_full_duplex, .adv_half_duplex, .mmd_req, .mmd_we,
      .target_device_select, .mmd_addr, .mmd_wdata, .mmd_ack, .mmd_rdata);

   // Far side of the indirect port: answers after a short stall; read
   // data churns while idle so a stale value cannot pass
   always @(posedge core_clk)
   begin
      mmd_ack <= 1'b0;
      mmd_rdata <= ~mmd_rdata;
      if (mmd_req === 1'b1 && !mmd_ack)
      begin
         ack_wait <= ack_wait + 1;
         if (ack_wait == 2)
         begin
            mmd_ack <= 1'b1;
            mmd_rdata <= mmd_addr ^ 16'h5a5a;
            ack_wait <= 0;
            last_wa <= mmd_we ? mmd_addr : last_wa;
            last_wd <= mmd_we ? mmd_wdata : last_wd;
         end
      end
   end
   ////////////////////////////////////////////////////////////
   // One bus cycle; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [15:0] d, output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {16'h0000, d};
      do
      begin
         @(posedge core_clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e,
      input string m);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      `CHK(q, {16'h0000, e}, m)
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rdc(8'h1c, 16'h2001, "np tx reset");
      rdc(8'h20, 16'h0000, "np rx reset");
      rdc(8'h24, 16'h0700, "gig ctrl reset");
      rdc(8'h28, 16'h4000, "gig stat reset");
      rdc(8'h34, 16'h0000, "mmd ctrl reset");
      rdc(8'h3c, 16'h3000, "ext1 word");
      rdc(8'h40, 16'h0000, "unmapped read");
      `CHK({force_master, force_slave}, 2'b00, "force reset")
      $display("test reset done");
   endtask

   // Toggle follows the inverse of the last sent word's toggle
   task automatic t_np();
      wr(8'h1c, 16'hffff);
      `CHK(np_tx_load, 1'b1, "np load pulse")
      rdc(8'h1c, 16'hb7ff, "np tx fields");
      for (int i = 0; i < 2; i++)
      begin
         @(posedge core_clk);
         lcw_sent <= 1'b1;
         lcw_sent_toggle <= i[0];
         @(posedge core_clk);
         lcw_sent <= 1'b0;
         rdc(8'h1c, {4'hb, !i[0], 11'h7ff}, "toggle");
      end
      $display("test next page done");
   endtask

   task automatic t_rx();
      @(posedge core_clk);
      page_rx <= 1'b1;
      page_rx_word <= 16'hc35a;
      @(posedge core_clk);
      page_rx <= 1'b0;
      page_rx_word <= 16'h3ca5;
      rdc(8'h20, 16'hc35a, "partner page");
      rdc(8'h18, 16'h0002, "page flag set");
      rdc(8'h18, 16'h0000, "page flag clear");
      $display("test receive done");
   endtask

   // All test modes and manual/value pairs, then one lane
   task automatic t_gig();
      logic [15:0] w;
      for (int i = 0; i < 8; i++)
      begin
         w = {i[2:0], i[0], i[1], 3'b010, 8'h5a};
         wr(8'h24, w); // no media sense here
         rdc(8'h24, w, "gig ctrl back");
         `CHK(test_mode, i[2:0], "test mode")
         `CHK(force_master, i[0] & i[1], "force master")
         `CHK(force_slave, i[0] & !i[1], "force slave")
         `CHK({multi_port, adv_full_duplex}, 2'b01, "adv")
      end
      avs_byteenable <= 4'h1;
      wr(8'h24, 16'hffff);
      avs_byteenable <= 4'h3;
      rdc(8'h24, 16'hfaff, "low lane only");
      wr(8'h24, 16'h0700);
      $display("test gigabit control done");
   endtask

   task automatic t_stat();
      @(posedge core_clk);
      {ms_fault, ms_resolved_master, idle_error} <= 3'b101;
      {local_rx_ok, remote_rx_ok, link_partner_full_duplex} <= 3'b111;
      repeat (3) @(posedge core_clk);
      {ms_fault, idle_error} <= 2'b00;
      @(posedge core_clk);
      rdc(8'h28, 16'hb803, "status snapshot");
      rdc(8'h28, 16'h3800, "cleared on read");
      ms_resolved_master <= 1'b1;
      {local_rx_ok, remote_rx_ok, link_partner_full_duplex} <= 3'b000;
      $display("test gigabit status done");
   endtask

   // Address, then each data function; far side echoes address-derived data
   task automatic t_mmd();
      wr(8'h34, 16'h3fe7);
      rdc(8'h34, 16'h3fe7, "mmd ctrl");
      `CHK(target_device_select, 5'h07, "device")
      wr(8'h38, 16'h0010);
      `CHK(mmd_addr, 16'h0010, "stored address")
      wr(8'h34, 16'h8007);
      rdc(8'h38, 16'h5a4a, "inc rw read");
      wr(8'h38, 16'h1234);
      `CHK({last_wa, last_wd, mmd_addr}, 48'h0011_1234_0012, "rw")
      wr(8'h34, 16'h4007);
      rdc(8'h38, 16'h5a48, "no inc read");
      wr(8'h34, 16'hc007);
      rdc(8'h38, 16'h5a48, "write inc read");
      wr(8'h38, 16'hbeef);
      `CHK({last_wa, last_wd, mmd_addr}, 48'h0012_beef_0013, "wo")
      $display("test indirect done");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      t_reset();
      t_np();
      t_rx();
      t_gig();
      t_stat();
      t_mmd();
      t_reset();
      give_verdict();
   end

   // Watchdog: the tests need a few hundred cycles at most
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule

bind pgm_regs pgm_regs_chk CHK (.*);

`default_nettype wire
